// File: design/flash_seq_pkg.sv
package flash_seq_pkg;
  // Instruction codes
  localparam logic [7:0] OPC_WREN = 8'h06;
  localparam logic [7:0] OPC_RDSR = 8'h05;
  localparam logic [7:0] OPC_QREAD = 8'hEB;
  localparam logic [7:0] OPC_PP = 8'h02;
  localparam logic [7:0] OPC_QPP = 8'h32;
  localparam logic [7:0] OPC_SE4K = 8'h20;
  localparam logic [7:0] OPC_BE32K = 8'h52;
  localparam logic [7:0] OPC_BE64K = 8'hD8;
  // Frame field last-rise indexes, counted from zero in serial clock rises
  localparam logic [4:0] OPC_LAST = 5'h07;
  localparam logic [4:0] ADDR1_LAST = 5'h17;
  localparam logic [4:0] ADDR4_LAST = 5'h05;
  localparam logic [4:0] MODE_DUMMY_LAST = 5'h05;
  localparam logic [4:0] BYTE1_LAST = 5'h07;
  localparam logic [4:0] BYTE4_LAST = 5'h01;
  localparam int PAGE_BYTES = 256;
  localparam logic [8:0] PAGE_END = 9'h100;
  // Status byte fields
  localparam int STAT_BUSY_POS = 0;
  localparam int STAT_WEL_POS = 1;
  // Erase sizes
  localparam logic [1:0] ERASE_4K = 2'h0;
  localparam logic [1:0] ERASE_32K = 2'h1;
  localparam logic [1:0] ERASE_64K = 2'h2;
  // Self-timed cycle lengths
  localparam int CLK_MHZ = 20;
  localparam int PROG_TIME_US = 400;
  localparam int SECTOR_ERASE_TIME_US = 45000;
  localparam int SMALL_BLOCK_ERASE_TIME_US = 120000;
  localparam int BLOCK_ERASE_TIME_US = 150000;
  localparam int PROG_CYCLES = PROG_TIME_US * CLK_MHZ;
  localparam int SECTOR_ERASE_CYCLES = SECTOR_ERASE_TIME_US * CLK_MHZ;
  localparam int SMALL_BLOCK_ERASE_CYCLES = SMALL_BLOCK_ERASE_TIME_US * CLK_MHZ;
  localparam int BLOCK_ERASE_CYCLES = BLOCK_ERASE_TIME_US * CLK_MHZ;

  typedef struct packed {
    logic cs_n;
    logic sclk;
    logic [3:0] lanes;
  } spi_pins_s;

  typedef struct packed {
    logic en;
    logic [23:0] addr;
    logic [7:0] data;
  } prog_wr_s;

  typedef struct packed {
    logic valid;
    logic [1:0] size;
    logic [23:0] addr;
  } erase_req_s;

  typedef enum logic [6:0] {
    S_OPC = 7'h01,
    S_ADDR = 7'h02,
    S_MODE = 7'h04,
    S_RD = 7'h08,
    S_PD = 7'h10,
    S_STAT = 7'h20,
    S_SKIP = 7'h40
  } frame_state_e;
endpackage : flash_seq_pkg

// File: design/flash_seq.sv
`timescale 1ns/1ps
module flash_seq #(
  parameter int PROG_CYCLES = flash_seq_pkg::PROG_CYCLES,
  parameter int SECTOR_ERASE_CYCLES = flash_seq_pkg::SECTOR_ERASE_CYCLES,
  parameter int SMALL_BLOCK_ERASE_CYCLES = flash_seq_pkg::SMALL_BLOCK_ERASE_CYCLES,
  parameter int BLOCK_ERASE_CYCLES = flash_seq_pkg::BLOCK_ERASE_CYCLES
) (
  input wire logic clk_i, // 20 MHz clock
  input wire logic resetn_i, // Async reset, low
  input wire flash_seq_pkg::spi_pins_s pins_i, // Select, serial clock, lanes in
  output logic [3:0] lane_o, // Lane output values
  output logic [3:0] lane_oe_o, // Lane output enables
  input wire logic quad_lane_enable_bit_i, // Quad enable status bit
  input wire logic protected_i, // Target at addr_o is protected
  output logic [23:0] addr_o, // Command address
  input wire logic [7:0] rd_data_i, // Array byte at addr_o
  output flash_seq_pkg::prog_wr_s prog_wr_o, // Array program strobe
  output flash_seq_pkg::erase_req_s erase_o, // Array erase pulse
  output logic busy_o, // Busy flag
  output logic write_enable_latch_o // Write enable latch
);
  localparam logic [23:0] PROG_N = 24'(PROG_CYCLES);
  localparam logic [23:0] SE_N = 24'(SECTOR_ERASE_CYCLES);
  localparam logic [23:0] BE32_N = 24'(SMALL_BLOCK_ERASE_CYCLES);
  localparam logic [23:0] BE64_N = 24'(BLOCK_ERASE_CYCLES);

  logic rst_s1_q;
  logic rst_n;
  flash_seq_pkg::spi_pins_s s1_q;
  flash_seq_pkg::spi_pins_s s2_q;
  flash_seq_pkg::spi_pins_s s3_q;
  logic sck_rise;
  logic sck_fall;
  logic cs_rise;

  flash_seq_pkg::frame_state_e state_q, state_d;
  logic [4:0] cnt_q, cnt_d;
  logic [7:0] opc_q, opc_d;
  logic [23:0] addr_q, addr_d;
  logic [7:0] sh_q, sh_d;
  logic ok_q, ok_d;
  logic quad_q, quad_d;
  logic nib_q, nib_d;
  logic [7:0] col_q, col_d;
  logic [3:0] lane_q, lane_d;
  logic [3:0] oe_q, oe_d;
  logic busy_q, busy_d;
  logic wel_q, wel_d;
  logic [23:0] tmr_q, tmr_d;
  logic [8:0] idx_q, idx_d;
  flash_seq_pkg::prog_wr_s wr_q, wr_d;
  flash_seq_pkg::erase_req_s er_q, er_d;

  logic [7:0] page_q [flash_seq_pkg::PAGE_BYTES];
  logic [flash_seq_pkg::PAGE_BYTES-1:0] mask_q, mask_d;
  logic pb_we;
  logic [7:0] pb_data;

  // Reset release through two flops
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_s1_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n <= rst_s1_q;
    end
  end

  // Pins pass two flops; third only for edge finding
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= '{cs_n: 1'b1, sclk: 1'b0, lanes: 4'h0};
      s2_q <= '{cs_n: 1'b1, sclk: 1'b0, lanes: 4'h0};
      s3_q <= '{cs_n: 1'b1, sclk: 1'b0, lanes: 4'h0};
    end else begin
      s1_q <= pins_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  assign sck_rise = s2_q.sclk & ~s3_q.sclk & ~s2_q.cs_n;
  assign sck_fall = ~s2_q.sclk & s3_q.sclk & ~s2_q.cs_n;
  assign cs_rise = s2_q.cs_n & ~s3_q.cs_n;

  always_comb begin
    logic [23:0] addr_n;
    logic [7:0] byte_n;
    logic [7:0] stat;
    addr_n = quad_q ? {addr_q[19:0], s2_q.lanes} : {addr_q[22:0], s2_q.lanes[0]};
    byte_n = quad_q ? {sh_q[3:0], s2_q.lanes} : {sh_q[6:0], s2_q.lanes[0]};
    stat = 8'h00;
    stat[flash_seq_pkg::STAT_BUSY_POS] = busy_q;
    stat[flash_seq_pkg::STAT_WEL_POS] = wel_q;
    state_d = state_q;
    cnt_d = cnt_q;
    opc_d = opc_q;
    addr_d = addr_q;
    sh_d = sh_q;
    ok_d = ok_q;
    quad_d = quad_q;
    nib_d = nib_q;
    col_d = col_q;
    lane_d = lane_q;
    oe_d = oe_q;
    busy_d = busy_q;
    wel_d = wel_q;
    tmr_d = tmr_q;
    idx_d = idx_q;
    mask_d = mask_q;
    pb_we = 1'b0;
    pb_data = byte_n;
    wr_d = '{en: 1'b0, addr: wr_q.addr, data: wr_q.data};
    er_d = '{valid: 1'b0, size: er_q.size, addr: er_q.addr};

    // Self-timed cycle; page buffer drained first
    if (busy_q) begin
      if (idx_q != flash_seq_pkg::PAGE_END) begin
        wr_d.en = mask_q[idx_q[7:0]];
        wr_d.addr = {addr_q[23:8], idx_q[7:0]};
        wr_d.data = page_q[idx_q[7:0]];
        idx_d = idx_q + 9'h001;
      end
      if (tmr_q == 24'h000000) begin
        busy_d = 1'b0;
        wel_d = 1'b0;
      end else begin
        tmr_d = tmr_q - 24'h000001;
      end
    end

    if (s2_q.cs_n) begin
      state_d = flash_seq_pkg::S_OPC;
      cnt_d = 5'h00;
      oe_d = 4'h0;
      ok_d = 1'b0;
    end

    // Only a cleanly ended frame takes effect
    if (cs_rise && ok_q) begin
      if (opc_q == flash_seq_pkg::OPC_WREN) begin
        wel_d = 1'b1;
      end else if (!protected_i) begin
        busy_d = 1'b1;
        idx_d = flash_seq_pkg::PAGE_END;
        if (opc_q == flash_seq_pkg::OPC_PP || opc_q == flash_seq_pkg::OPC_QPP) begin
          tmr_d = PROG_N;
          idx_d = 9'h000;
        end else if (opc_q == flash_seq_pkg::OPC_SE4K) begin
          tmr_d = SE_N;
          er_d = '{valid: 1'b1, size: flash_seq_pkg::ERASE_4K, addr: addr_q};
        end else if (opc_q == flash_seq_pkg::OPC_BE32K) begin
          tmr_d = BE32_N;
          er_d = '{valid: 1'b1, size: flash_seq_pkg::ERASE_32K, addr: addr_q};
        end else begin
          tmr_d = BE64_N;
          er_d = '{valid: 1'b1, size: flash_seq_pkg::ERASE_64K, addr: addr_q};
        end
      end
    end

    if (sck_rise) begin
      cnt_d = cnt_q + 5'h01;
      case (state_q)
        flash_seq_pkg::S_OPC: begin
          sh_d = {sh_q[6:0], s2_q.lanes[0]};
          if (cnt_q == flash_seq_pkg::OPC_LAST) begin
            opc_d = {sh_q[6:0], s2_q.lanes[0]};
            cnt_d = 5'h00;
            state_d = flash_seq_pkg::S_SKIP;
            quad_d = 1'b0;
            case ({sh_q[6:0], s2_q.lanes[0]})
              flash_seq_pkg::OPC_RDSR: state_d = flash_seq_pkg::S_STAT;
              flash_seq_pkg::OPC_WREN: ok_d = ~busy_q;
              flash_seq_pkg::OPC_QREAD: begin
                if (quad_lane_enable_bit_i && !busy_q) begin
                  state_d = flash_seq_pkg::S_ADDR;
                  quad_d = 1'b1;
                end
              end
              flash_seq_pkg::OPC_QPP: begin
                if (quad_lane_enable_bit_i && wel_q && !busy_q) begin
                  state_d = flash_seq_pkg::S_ADDR;
                  quad_d = 1'b1;
                  mask_d = '0;
                end
              end
              flash_seq_pkg::OPC_PP, flash_seq_pkg::OPC_SE4K,
              flash_seq_pkg::OPC_BE32K, flash_seq_pkg::OPC_BE64K: begin
                if (wel_q && !busy_q) begin
                  state_d = flash_seq_pkg::S_ADDR;
                  // Mask cleared only on an accepted PP, QPP or erase opcode; a status poll must not cut the drain
                  mask_d = '0;
                end
              end
              default: state_d = flash_seq_pkg::S_SKIP;
            endcase
          end
        end
        flash_seq_pkg::S_ADDR: begin
          addr_d = addr_n;
          if (cnt_q == (quad_q ? flash_seq_pkg::ADDR4_LAST : flash_seq_pkg::ADDR1_LAST)) begin
            cnt_d = 5'h00;
            col_d = addr_n[7:0];
            if (opc_q == flash_seq_pkg::OPC_QREAD) begin
              state_d = flash_seq_pkg::S_MODE;
            end else if (opc_q == flash_seq_pkg::OPC_PP || opc_q == flash_seq_pkg::OPC_QPP) begin
              state_d = flash_seq_pkg::S_PD;
            end else begin
              state_d = flash_seq_pkg::S_SKIP;
              ok_d = 1'b1;
            end
          end
        end
        flash_seq_pkg::S_MODE: begin
          // Mode bits are not acted on; lanes stay released
          if (cnt_q == flash_seq_pkg::MODE_DUMMY_LAST) begin
            state_d = flash_seq_pkg::S_RD;
            cnt_d = 5'h00;
            nib_d = 1'b0;
          end
        end
        flash_seq_pkg::S_PD: begin
          sh_d = byte_n;
          ok_d = 1'b0;
          if (cnt_q == (quad_q ? flash_seq_pkg::BYTE4_LAST : flash_seq_pkg::BYTE1_LAST)) begin
            cnt_d = 5'h00;
            pb_we = 1'b1;
            mask_d[col_q] = 1'b1;
            col_d = col_q + 8'h01;
            ok_d = 1'b1;
          end
        end
        flash_seq_pkg::S_SKIP: ok_d = 1'b0;
        default: cnt_d = cnt_q;
      endcase
    end

    if (sck_fall) begin
      if (state_q == flash_seq_pkg::S_STAT) begin
        oe_d = 4'h2;
        cnt_d = (cnt_q[2:0] == 3'h7) ? 5'h00 : cnt_q + 5'h01;
        if (cnt_q[2:0] == 3'h0) begin
          lane_d = {2'h0, stat[7], 1'b0};
          sh_d = {stat[6:0], 1'b0};
        end else begin
          lane_d = {2'h0, sh_q[7], 1'b0};
          sh_d = {sh_q[6:0], 1'b0};
        end
      end else if (state_q == flash_seq_pkg::S_RD) begin
        oe_d = 4'hF;
        nib_d = ~nib_q;
        if (!nib_q) begin
          lane_d = rd_data_i[7:4];
        end else begin
          lane_d = rd_data_i[3:0];
          addr_d = addr_q + 24'h000001;
        end
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= flash_seq_pkg::S_OPC;
      cnt_q <= 5'h00;
      opc_q <= 8'h00;
      addr_q <= 24'h000000;
      sh_q <= 8'h00;
      ok_q <= 1'b0;
      quad_q <= 1'b0;
      nib_q <= 1'b0;
      col_q <= 8'h00;
      lane_q <= 4'h0;
      oe_q <= 4'h0;
      busy_q <= 1'b0;
      wel_q <= 1'b0;
      tmr_q <= 24'h000000;
      idx_q <= flash_seq_pkg::PAGE_END;
      mask_q <= '0;
      wr_q <= '0;
      er_q <= '0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      opc_q <= opc_d;
      addr_q <= addr_d;
      sh_q <= sh_d;
      ok_q <= ok_d;
      quad_q <= quad_d;
      nib_q <= nib_d;
      col_q <= col_d;
      lane_q <= lane_d;
      oe_q <= oe_d;
      busy_q <= busy_d;
      wel_q <= wel_d;
      tmr_q <= tmr_d;
      idx_q <= idx_d;
      mask_q <= mask_d;
      wr_q <= wr_d;
      er_q <= er_d;
    end
  end

  // Page buffer; data only, validity lives in mask_q
  always_ff @(posedge clk_i) begin
    if (pb_we) begin
      page_q[col_q] <= pb_data;
    end
  end

  assign lane_o = lane_q;
  assign lane_oe_o = oe_q;
  assign addr_o = addr_q;
  assign prog_wr_o = wr_q;
  assign erase_o = er_q;
  assign busy_o = busy_q;
  assign write_enable_latch_o = wel_q;
endmodule : flash_seq

// File: verif/flash_seq_sva.sv
`timescale 1ns/1ps
module flash_seq_sva (
  input wire logic clk_i, // Clock
  input wire logic resetn_i, // Reset, low
  input wire flash_seq_pkg::spi_pins_s pins_i, // Pins
  input wire logic [3:0] lane_oe_o, // Lane enables
  input wire logic protected_i, // Protection
  input wire flash_seq_pkg::prog_wr_s prog_wr_o, // Program strobe
  input wire flash_seq_pkg::erase_req_s erase_o, // Erase pulse
  input wire logic busy_o, // Busy
  input wire logic write_enable_latch_o // Latch
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  chk_prog_in_cycle: assert property (prog_wr_o.en |-> busy_o && write_enable_latch_o)
    else $error("program strobe outside cycle");
  chk_erase_guard: assert property (erase_o.valid |-> write_enable_latch_o && !$past(protected_i))
    else $error("erase without latch or on protected target");
  chk_erase_single: assert property (erase_o.valid |=> !erase_o.valid)
    else $error("erase pulse too long");
  chk_erase_busy: assert property (erase_o.valid |-> ##[0:2] busy_o [*8])
    else $error("erase without busy");
  chk_latch_clear: assert property ($fell(busy_o) |-> !write_enable_latch_o)
    else $error("latch kept after cycle");
  chk_busy_hold: assert property ($rose(busy_o) |=> busy_o [*8])
    else $error("busy dropped early");
  chk_prog_page: assert property (prog_wr_o.en && $past(prog_wr_o.en)
    |-> prog_wr_o.addr[23:8] == $past(prog_wr_o.addr[23:8]))
    else $error("program left its page");
  chk_oe_frame: assert property (lane_oe_o != 4'h0
    |-> !$past(pins_i.cs_n, 5) && lane_oe_o inside {4'h2, 4'hF})
    else $error("lanes driven outside frame");
  cov_erase: cover property (erase_o.valid);
  cov_prog: cover property (prog_wr_o.en);
  cov_quad: cover property (lane_oe_o == 4'hF);
endmodule : flash_seq_sva
bind flash_seq flash_seq_sva sva (.clk_i(clk_i), .resetn_i(resetn_i), .pins_i(pins_i),
  .lane_oe_o(lane_oe_o), .protected_i(protected_i), .prog_wr_o(prog_wr_o),
  .erase_o(erase_o), .busy_o(busy_o), .write_enable_latch_o(write_enable_latch_o));

// File: verif/spi_host.sv
`timescale 1ns/1ps
module spi_host (
  input wire logic clk_i, // Bench clock
  input wire logic [3:0] lane_i, // Device lane values
  input wire logic [3:0] lane_oe_i, // Device lane enables
  output flash_seq_pkg::spi_pins_s pins_o // Wire levels seen by device
);
  logic [3:0] drv = 4'h0;
  logic own = 1'b1;
  logic cs_n = 1'b1;
  logic sclk = 1'b0;
  // Released lanes show the inverse, so stale data cannot pass
  always_comb begin
    pins_o.cs_n = cs_n;
    pins_o.sclk = sclk;
    pins_o.lanes = (lane_oe_i & lane_i) | (~lane_oe_i & (own ? drv : ~drv));
  end
  task automatic tick(input int n);
    repeat (n) @(negedge clk_i);
  endtask : tick
  task automatic sel(input logic s);
    tick(4);
    cs_n = s;
    tick(4);
  endtask : sel
  // Clock stands low between frames; device reads on the rise
  task automatic shift(input logic [31:0] v, input int n, input logic q, input logic rel,
                       output logic [31:0] r);
    r = 32'h0;
    v = v << (32 - n * (q ? 4 : 1));
    own = !rel;
    for (int i = 0; i < n; i++) begin
      if (q) drv = v[31:28];
      else drv[0] = v[31];
      v = v << (q ? 4 : 1);
      tick(4);
      sclk = 1'b1;
      tick(3);
      r = q ? {r[27:0], pins_o.lanes} : {r[30:0], pins_o.lanes[1]};
      tick(1);
      sclk = 1'b0;
    end
  endtask : shift
endmodule : spi_host

// File: verif/tb_flash_seq.sv
`timescale 1ns/1ps
module tb_flash_seq;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic qe = 1'b0;
  logic [11:0] prot_blk = 12'hFFF;
  int quad_oe_cnt = 0;
  int oe_seen = 0;
  logic [7:0] mem [0:511] = '{default: 8'hFF};
  logic [3:0] lane_o;
  logic [3:0] lane_oe_o;
  logic [23:0] addr_o;
  logic busy;
  logic write_enable_latch;
  logic [31:0] r;
  logic [25:0] er_last = 26'h0;
  int er_cnt = 0;
  int num_errors = 0;
  int check_count = 0;
  flash_seq_pkg::spi_pins_s pins;
  flash_seq_pkg::prog_wr_s prog_wr;
  flash_seq_pkg::erase_req_s erase;
  wire logic [7:0] rd_data = mem[addr_o[8:0]];
  // Protection decode model: one 4 KB block locked at a time
  wire logic prot = (addr_o[23:12] == prot_blk);
  flash_seq #(.PROG_CYCLES(300), .SECTOR_ERASE_CYCLES(50), .SMALL_BLOCK_ERASE_CYCLES(50),
    .BLOCK_ERASE_CYCLES(400)) dut (.clk_i(clk_i), .resetn_i(resetn_i), .pins_i(pins),
    .lane_o(lane_o), .lane_oe_o(lane_oe_o), .quad_lane_enable_bit_i(qe),
    .protected_i(prot), .addr_o(addr_o), .rd_data_i(rd_data), .prog_wr_o(prog_wr),
    .erase_o(erase), .busy_o(busy), .write_enable_latch_o(write_enable_latch));
  spi_host host (.clk_i(clk_i), .lane_i(lane_o), .lane_oe_i(lane_oe_o), .pins_o(pins));
  initial forever #25 clk_i = ~clk_i;
  // Small array: any erase clears the whole model, enough for these checks
  always @(posedge clk_i) begin
    if (prog_wr.en) mem[prog_wr.addr[8:0]] <= mem[prog_wr.addr[8:0]] & prog_wr.data;
    if (erase.valid) begin
      for (int i = 0; i < 512; i++) mem[i] <= 8'hFF;
      er_cnt <= er_cnt + 1;
      er_last <= {erase.size, erase.addr};
    end
    if (lane_oe_o == 4'hF) quad_oe_cnt <= quad_oe_cnt + 1;
  end
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk
  task automatic tend(input string s);
    $display("test %s done", s);
  endtask : tend
  task automatic pp(input logic [7:0] op, input logic [23:0] a, input logic [31:0] d,
                    input int n, input logic q);
    host.sel(1'b0);
    host.shift({24'h0, op}, 8, 1'b0, 1'b0, r);
    host.shift({8'h0, a}, q ? 6 : 24, q, 1'b0, r);
    host.shift(d, n, q, 1'b0, r);
    host.sel(1'b1);
    host.tick(8);
  endtask : pp
  // Opcode only: trailing clocks would discard it
  task automatic wren();
    host.sel(1'b0);
    host.shift(32'h06, 8, 1'b0, 1'b0, r);
    host.sel(1'b1);
    host.tick(8);
  endtask : wren
  task automatic stat(input logic [7:0] e);
    host.sel(1'b0);
    host.shift(32'h05, 8, 1'b0, 1'b0, r);
    host.shift(32'h0, 8, 1'b0, 1'b1, r);
    host.sel(1'b1);
    chk(r[7:0], e);
  endtask : stat
  task automatic qrd(input logic [23:0] a, input int n);
    host.sel(1'b0);
    host.shift(32'hEB, 8, 1'b0, 1'b0, r);
    host.shift({a, 8'hF0}, 8, 1'b1, 1'b0, r);
    host.shift(32'h0, 4, 1'b1, 1'b0, r);
    host.shift(32'h0, n, 1'b1, 1'b1, r);
    host.sel(1'b1);
  endtask : qrd
  task automatic wait_idle();
    int i;
    for (i = 0; i < 2000 && busy !== 1'b0; i++) @(negedge clk_i);
    if (i == 2000) begin
      num_errors++;
      wrap_up();
    end
  endtask : wait_idle
  initial begin
    repeat (4) @(negedge clk_i);
    resetn_i = 1'b1;
    repeat (8) @(negedge clk_i);
    chk({busy, write_enable_latch, lane_oe_o}, 32'h0);
    pp(8'h02, 24'h000010, 32'h11, 8, 1'b0);
    chk(mem[16], 8'hFF);
    stat(8'h00);
    tend("no latch");
    wren();
    stat(8'h02);
    pp(8'h02, 24'h0000FE, 32'hA1B2C3, 24, 1'b0);
    stat(8'h03);
    wait_idle();
    stat(8'h00);
    chk({mem[254], mem[255], mem[0]}, 24'hA1B2C3);
    chk(mem[1], 8'hFF);
    tend("page wrap");
    oe_seen = quad_oe_cnt;
    qrd(24'h0000FE, 6);
    chk(quad_oe_cnt, oe_seen);
    qe = 1'b1;
    qrd(24'h0000FE, 6);
    chk(r[23:0], 24'hA1B2FF);
    tend("quad read");
    wren();
    pp(8'h02, 24'h000020, 32'h5, 4, 1'b0);
    stat(8'h02);
    prot_blk = 12'h000;
    pp(8'h02, 24'h000020, 32'h00, 8, 1'b0);
    prot_blk = 12'hFFF;
    stat(8'h02);
    chk(mem[32], 8'hFF);
    tend("refusals");
    qe = 1'b0;
    pp(8'h32, 24'h000100, 32'h5A, 2, 1'b1);
    stat(8'h02);
    qe = 1'b1;
    pp(8'h32, 24'h000100, 32'h5A, 2, 1'b1);
    wait_idle();
    chk(mem[256], 8'h5A);
    stat(8'h00);
    tend("quad program");
    for (int k = 0; k < 3; k++) begin
      wren();
      pp(k == 0 ? 8'h20 : k == 1 ? 8'h52 : 8'hD8, 24'h012345, 32'h0, 0, 1'b0);
      chk(er_last, {k[1:0], 24'h012345});
      chk(mem[256], 8'hFF);
      if (k == 2) begin
        oe_seen = quad_oe_cnt;
        qrd(24'h0, 2);
        chk(quad_oe_cnt, oe_seen);
      end
      wait_idle();
      stat(8'h00);
    end
    tend("erase sizes");
    pp(8'h20, 24'h001000, 32'h0, 0, 1'b0);
    wren();
    pp(8'h20, 24'h001000, 32'h1, 1, 1'b0);
    prot_blk = 12'h001;
    pp(8'h20, 24'h001000, 32'h0, 0, 1'b0);
    prot_blk = 12'hFFF;
    chk(er_cnt, 3);
    stat(8'h02);
    tend("erase refusals");
    wrap_up();
  end
endmodule : tb_flash_seq
